// File: verilog/tsviu_pkg.sv
package tsviu_pkg;
  // ****************************************
  // Register map and field layout
  // ****************************************
  localparam logic [7:0] IRQ_CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h01;
  localparam logic [7:0] STACK_ADDR = 8'h02;
  localparam int GIE_BIT = 0;
  localparam int EXT_EN_BIT = 1;
  localparam int TMR_EN_BIT = 2;
  localparam int ADC_EN_BIT = 3;
  localparam int EXT_FLAG_BIT = 4;
  localparam int TMR_FLAG_BIT = 5;
  localparam int ADC_FLAG_BIT = 6;
  localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
  // ****************************************
  // Vectors
  // ****************************************
  localparam logic [11:0] EXT_VECTOR = 12'h004;
  localparam logic [11:0] TMR_VECTOR = 12'h008;
  localparam logic [11:0] ADC_VECTOR = 12'h00c;
  localparam int PC_WIDTH = 12;
  localparam int STACK_DEPTH = 6;
endpackage

// File: verilog/tsviu_core.sv
`timescale 1ns/100ps
// Operation
// - Falling edge on pin sets external flag
// - Timer overflow sets timer flag
// - Conversion done sets converter flag
// - Service needs global and source enable
// - External request vectors to 04H
// - Timer request vectors to 08H
// - Converter request vectors to 0CH
// - Push next PC then load vector
// - Only program counter saved by hardware
// - Servicing clears global enable
// - Servicing clears that source flag
// - Disabled requests still set flags
// - Flags stay until serviced or cleared
// - Full stack holds off acknowledge
// - Return pops saved program counter
// - Requests sampled at phase two pulse
// - Priority external, timer, then converter
// - Any source wakes from power-down
module tsviu_core #(
  parameter int PCW = tsviu_pkg::PC_WIDTH,
  parameter int DEPTH = tsviu_pkg::STACK_DEPTH
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Event sources
  input wire logic ext_irq_pin,
  input wire logic timer_overflow,
  input wire logic adc_done,
  // Core sequencer
  input wire logic phase_two_pulse,
  input wire logic [PCW-1:0] next_pc,
  input wire logic reti,
  input wire logic power_down,
  output logic irq_ack,
  output logic [PCW-1:0] vector_pc,
  output logic [1:0] vector_sel,
  output logic [PCW-1:0] return_pc,
  output logic return_valid,
  output logic stack_full,
  output logic wake
);
  // ****************************************
  // Pin synchroniser and edge detect
  // ****************************************
  logic pin_s1_r, pin_s2_r, pin_d_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_s1_r <= 1'b1;
      pin_s2_r <= 1'b1;
      pin_d_r <= 1'b1;
    end
    else if (clk_en)
    begin
      pin_s1_r <= ext_irq_pin;
      pin_s2_r <= pin_s1_r;
      pin_d_r <= pin_s2_r;
    end
  end
  logic ext_fall;
  assign ext_fall = pin_d_r & ~pin_s2_r;

  // ****************************************
  // Control register and stack
  // ****************************************
  logic global_irq_enable, ext_irq_enable, timer_irq_enable, adc_irq_enable;
  logic ext_irq_flag, timer_overflow_flag, adc_done_flag;
  logic [PCW-1:0] stack_r [DEPTH];
  logic [$clog2(DEPTH+1)-1:0] sp_r;
  logic wr_ctrl, take, pop;
  logic [2:0] sel;
  assign wr_ctrl = reg_wr && reg_addr == tsviu_pkg::IRQ_CTRL_ADDR;
  assign stack_full = sp_r == ($clog2(DEPTH+1))'(DEPTH);
  assign pop = reti && sp_r != '0;
  // A return and an entry in one cycle share the slot the return frees
  logic [$clog2(DEPTH)-1:0] push_idx;
  assign push_idx = pop ? sp_r[$clog2(DEPTH)-1:0] - 1'b1 : sp_r[$clog2(DEPTH)-1:0];

  // Priority pick, one hot
  always_comb
  begin
    sel = 3'b000;
    if (global_irq_enable && !stack_full && phase_two_pulse)
    begin
      if (ext_irq_flag && ext_irq_enable)
        sel = 3'b001;
      else if (timer_overflow_flag && timer_irq_enable)
        sel = 3'b010;
      else if (adc_done_flag && adc_irq_enable)
        sel = 3'b100;
    end
  end
  assign take = |sel;

  // Enables: software writes; service drops the global one
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      {adc_irq_enable, timer_irq_enable, ext_irq_enable, global_irq_enable} <= 4'h0;
    end
    else if (clk_en)
    begin
      if (wr_ctrl)
      begin
        global_irq_enable <= reg_wdata[tsviu_pkg::GIE_BIT];
        ext_irq_enable <= reg_wdata[tsviu_pkg::EXT_EN_BIT];
        timer_irq_enable <= reg_wdata[tsviu_pkg::TMR_EN_BIT];
        adc_irq_enable <= reg_wdata[tsviu_pkg::ADC_EN_BIT];
      end
      if (take)
        global_irq_enable <= 1'b0;
    end
  end

  // Flags: set by events regardless of enables; set beats clear
  function automatic logic flag_next(input logic cur, input logic set, input logic wr,
                                     input logic wbit, input logic svc);
    logic v;
    v = cur;
    if (wr)
      v = wbit;
    if (svc)
      v = 1'b0;
    if (set)
      v = 1'b1;
    return v;
  endfunction

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ext_irq_flag <= 1'b0;
      timer_overflow_flag <= 1'b0;
      adc_done_flag <= 1'b0;
    end
    else if (clk_en)
    begin
      ext_irq_flag <= flag_next(ext_irq_flag, ext_fall, wr_ctrl,
                                reg_wdata[tsviu_pkg::EXT_FLAG_BIT], sel[0]);
      timer_overflow_flag <= flag_next(timer_overflow_flag, timer_overflow, wr_ctrl,
                                       reg_wdata[tsviu_pkg::TMR_FLAG_BIT], sel[1]);
      adc_done_flag <= flag_next(adc_done_flag, adc_done, wr_ctrl,
                                 reg_wdata[tsviu_pkg::ADC_FLAG_BIT], sel[2]);
    end
  end

  // Return-address stack: only the program counter is kept
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      sp_r <= '0;
    else if (clk_en)
    begin
      if (take && !pop)
        sp_r <= sp_r + 1'b1;
      else if (pop && !take)
        sp_r <= sp_r - 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (clk_en && take)
      stack_r[push_idx] <= next_pc;
  end

  // ****************************************
  // Core-facing outputs
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      irq_ack <= 1'b0;
      vector_pc <= '0;
      vector_sel <= 2'h0;
      return_pc <= '0;
      return_valid <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_ack <= take;
      return_valid <= pop;
      if (pop)
        return_pc <= stack_r[sp_r[$clog2(DEPTH)-1:0] - 1'b1];
      if (take)
      begin
        vector_sel <= sel[0] ? 2'h1 : sel[1] ? 2'h2 : 2'h3;
        vector_pc <= sel[0] ? PCW'(tsviu_pkg::EXT_VECTOR)
                   : sel[1] ? PCW'(tsviu_pkg::TMR_VECTOR)
                   : PCW'(tsviu_pkg::ADC_VECTOR);
      end
    end
  end

  // Wake ignores enables so any source can end power-down
  assign wake = power_down & (ext_irq_flag | timer_overflow_flag | adc_done_flag);

  // ****************************************
  // Register read
  // ****************************************
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 8'h00;
    else if (clk_en)
    begin
      reg_rdata <= 8'h00;
      if (reg_rd)
      begin
        unique case (reg_addr)
          tsviu_pkg::IRQ_CTRL_ADDR: reg_rdata <= {1'b0, adc_done_flag, timer_overflow_flag,
                                                  ext_irq_flag, adc_irq_enable, timer_irq_enable,
                                                  ext_irq_enable, global_irq_enable};
          tsviu_pkg::STATUS_ADDR: reg_rdata <= {6'h00, power_down, stack_full};
          tsviu_pkg::STACK_ADDR: reg_rdata <= 8'(sp_r);
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  property p_ack_clears_gie;
    @(posedge clk) disable iff (!rst_n) clk_en && take |=> !global_irq_enable;
  endproperty
  a_ack_clears_gie: assert property (p_ack_clears_gie) else $error("gie not cleared");
  property p_no_take_full;
    @(posedge clk) disable iff (!rst_n) stack_full |-> !take;
  endproperty
  a_no_take_full: assert property (p_no_take_full) else $error("ack while full");
  property p_take_phase;
    @(posedge clk) disable iff (!rst_n) take |-> phase_two_pulse && global_irq_enable;
  endproperty
  a_take_phase: assert property (p_take_phase) else $error("ack outside phase");
  property p_ext_prio;
    @(posedge clk) disable iff (!rst_n) take && ext_irq_flag && ext_irq_enable |-> sel[0];
  endproperty
  a_ext_prio: assert property (p_ext_prio) else $error("priority wrong");
  property p_ext_vec;
    @(posedge clk) disable iff (!rst_n)
      clk_en && sel[0] |=> irq_ack && vector_pc == PCW'(tsviu_pkg::EXT_VECTOR);
  endproperty
  a_ext_vec: assert property (p_ext_vec) else $error("ext vector wrong");
  property p_tmr_vec;
    @(posedge clk) disable iff (!rst_n)
      clk_en && sel[1] |=> vector_pc == PCW'(tsviu_pkg::TMR_VECTOR);
  endproperty
  a_tmr_vec: assert property (p_tmr_vec) else $error("timer vector wrong");
  property p_adc_vec;
    @(posedge clk) disable iff (!rst_n)
      clk_en && sel[2] |=> vector_pc == PCW'(tsviu_pkg::ADC_VECTOR);
  endproperty
  a_adc_vec: assert property (p_adc_vec) else $error("adc vector wrong");
  property p_tmr_set;
    @(posedge clk) disable iff (!rst_n) clk_en && timer_overflow |=> timer_overflow_flag;
  endproperty
  a_tmr_set: assert property (p_tmr_set) else $error("timer flag lost");
  property p_adc_set;
    @(posedge clk) disable iff (!rst_n) clk_en && adc_done |=> adc_done_flag;
  endproperty
  a_adc_set: assert property (p_adc_set) else $error("adc flag lost");
  property p_push;
    @(posedge clk) disable iff (!rst_n) clk_en && take && !pop |=> sp_r == $past(sp_r) + 1'b1;
  endproperty
  a_push: assert property (p_push) else $error("stack not pushed");
  property p_ext_set;
    @(posedge clk) disable iff (!rst_n) clk_en && ext_fall |=> ext_irq_flag;
  endproperty
  a_ext_set: assert property (p_ext_set) else $error("ext flag lost");
  property p_no_gie;
    @(posedge clk) disable iff (!rst_n) !global_irq_enable |-> !take;
  endproperty
  a_no_gie: assert property (p_no_gie) else $error("ack with global enable low");
  property p_src_en;
    @(posedge clk) disable iff (!rst_n)
      take |-> (sel[0] && ext_irq_enable) || (sel[1] && timer_irq_enable) || (sel[2] && adc_irq_enable);
  endproperty
  a_src_en: assert property (p_src_en) else $error("ack of disabled source");
  property p_ext_clr;
    @(posedge clk) disable iff (!rst_n) clk_en && sel[0] && !ext_fall |=> !ext_irq_flag;
  endproperty
  a_ext_clr: assert property (p_ext_clr) else $error("ext flag not cleared");
  property p_tmr_clr;
    @(posedge clk) disable iff (!rst_n) clk_en && sel[1] && !timer_overflow |=> !timer_overflow_flag;
  endproperty
  a_tmr_clr: assert property (p_tmr_clr) else $error("timer flag not cleared");
  property p_adc_clr;
    @(posedge clk) disable iff (!rst_n) clk_en && sel[2] && !adc_done |=> !adc_done_flag;
  endproperty
  a_adc_clr: assert property (p_adc_clr) else $error("adc flag not cleared");
  property p_ext_keep;
    @(posedge clk) disable iff (!rst_n)
      clk_en && ext_irq_flag && !sel[0] && !wr_ctrl |=> ext_irq_flag;
  endproperty
  a_ext_keep: assert property (p_ext_keep) else $error("ext flag dropped");
  property p_tmr_keep;
    @(posedge clk) disable iff (!rst_n)
      clk_en && timer_overflow_flag && !sel[1] && !wr_ctrl |=> timer_overflow_flag;
  endproperty
  a_tmr_keep: assert property (p_tmr_keep) else $error("timer flag dropped");
  property p_adc_keep;
    @(posedge clk) disable iff (!rst_n)
      clk_en && adc_done_flag && !sel[2] && !wr_ctrl |=> adc_done_flag;
  endproperty
  a_adc_keep: assert property (p_adc_keep) else $error("adc flag dropped");
  property p_tmr_prio;
    @(posedge clk) disable iff (!rst_n)
      take && !(ext_irq_flag && ext_irq_enable) && timer_overflow_flag && timer_irq_enable |-> sel[1];
  endproperty
  a_tmr_prio: assert property (p_tmr_prio) else $error("timer priority wrong");
  property p_one_sel;
    @(posedge clk) disable iff (!rst_n) $onehot0(sel);
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("more than one source picked");
  property p_ack_once;
    @(posedge clk) disable iff (!rst_n) clk_en && irq_ack |=> !irq_ack;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
  property p_vec_sel;
    @(posedge clk) disable iff (!rst_n) clk_en && take |=> vector_sel != 2'h0;
  endproperty
  a_vec_sel: assert property (p_vec_sel) else $error("no vector select");
  property p_pop;
    @(posedge clk) disable iff (!rst_n)
      clk_en && pop && !take |=> sp_r == $past(sp_r) - 1'b1;
  endproperty
  a_pop: assert property (p_pop) else $error("stack not popped");
  property p_ret_valid;
    @(posedge clk) disable iff (!rst_n) clk_en && pop |=> return_valid;
  endproperty
  a_ret_valid: assert property (p_ret_valid) else $error("return not flagged");
  property p_wake;
    @(posedge clk) disable iff (!rst_n)
      clk_en && power_down && adc_done |=> wake || !power_down;
  endproperty
  a_wake: assert property (p_wake) else $error("no wake on event");
  property p_freeze;
    @(posedge clk) disable iff (!rst_n)
      !clk_en |=> $stable(sp_r) && $stable(global_irq_enable) && $stable(timer_overflow_flag);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");
endmodule

// File: dv/tsviu_core_model.sv
`timescale 1ns/100ps
// ****************************************
// Core sequencer stand-in
// ****************************************
// Phase pulse every fourth cycle; fetch address free-running so each push differs
module tsviu_core_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Sequencer side
  output logic phase_two_pulse,
  output logic [11:0] next_pc
);
  logic [1:0] ph_r;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ph_r <= 2'h0;
      next_pc <= 12'h100;
    end
    else
    begin
      ph_r <= ph_r + 2'h1;
      next_pc <= next_pc + 12'h001;
    end
  end
  assign phase_two_pulse = (ph_r == 2'h3);
endmodule

// File: dv/three_source_vectored_interrupt_unit_bench.sv
`timescale 1ns/100ps
// ****************************************
// Bench for the interrupt unit
// ****************************************
module three_source_vectored_interrupt_unit_bench;
  logic clk, rst_n, reg_wr, reg_rd, ext_irq_pin, timer_overflow, adc_done, reti, power_down;
  logic phase_two_pulse, irq_ack, return_valid, stack_full, wake, clk_en;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, m_ctrl;
  logic [11:0] next_pc, vector_pc, return_pc;
  logic [1:0] vector_sel;
  logic [31:0] seed;
  logic [11:0] pc_q[$];
  logic [11:0] vec[3] = '{tsviu_pkg::EXT_VECTOR, tsviu_pkg::TMR_VECTOR, tsviu_pkg::ADC_VECTOR};
  int num_errors, checks_done;
  tsviu_core_model u_core (.clk(clk), .rst_n(rst_n), .phase_two_pulse(phase_two_pulse),
    .next_pc(next_pc));
  tsviu_core u_dut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_irq_pin(ext_irq_pin), .timer_overflow(timer_overflow), .adc_done(adc_done),
    .phase_two_pulse(phase_two_pulse), .next_pc(next_pc), .reti(reti),
    .power_down(power_down), .irq_ack(irq_ack), .vector_pc(vector_pc),
    .vector_sel(vector_sel), .return_pc(return_pc), .return_valid(return_valid),
    .stack_full(stack_full), .wake(wake));
  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] x;
    x = v ^ (v << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task automatic final_report;
    if (num_errors == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("MISMATCH %0t %h %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    chk({4'h0, reg_rdata}, {4'h0, e});
  endtask
  // Same-clock one-cycle event: timer when t is set, converter otherwise
  task automatic pulse(input logic t);
    @(posedge clk);
    timer_overflow <= t;
    adc_done <= !t;
    @(posedge clk);
    timer_overflow <= 1'b0;
    adc_done <= 1'b0;
  endtask
  task automatic wait_ack(input int k);
    int n;
    n = 0;
    do
    begin
      @(negedge clk);
      n++;
    end
    while (irq_ack !== 1'b1 && n < 40);
    if (irq_ack !== 1'b1)
    begin
      num_errors++;
      final_report();
    end
    else
    begin
      chk(vector_pc, vec[k]);
      chk({10'h0, vector_sel}, 12'(k + 1));
      pc_q.push_back(next_pc - 12'h001);
      m_ctrl[0] = 1'b0;
      m_ctrl[4 + k] = 1'b0;
    end
  endtask
  task automatic ret;
    @(posedge clk);
    reti <= 1'b1;
    @(posedge clk);
    reti <= 1'b0;
    @(negedge clk);
    chk({11'h0, return_valid}, 12'h001);
    chk(return_pc, pc_q.pop_back());
  endtask
  initial
  begin
    {rst_n, reg_wr, reg_rd, timer_overflow, adc_done, reti, power_down} = '0;
    {reg_addr, reg_wdata} = '0;
    ext_irq_pin = 1'b1;
    clk_en = 1'b1;
    m_ctrl = 8'h00;
    seed = 32'h72d454ba;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    rd(8'h00, 8'h00);
    seed = xs(seed);
    rd(seed[7:0] | 8'h04, 8'h00);
    // Flags latch with everything disabled
    @(posedge clk);
    ext_irq_pin <= 1'b0;
    pulse(1'b1);
    pulse(1'b0);
    repeat (6) @(posedge clk);
    ext_irq_pin <= 1'b1;
    m_ctrl = 8'h70;
    rd(8'h00, m_ctrl);
    wr(8'h00, 8'h7f);
    m_ctrl = 8'h7f;
    for (int k = 0; k < 3; k++)
    begin
      wait_ack(k);
      rd(8'h00, m_ctrl);
      wr(8'h00, m_ctrl | 8'h01);
      m_ctrl[0] = 1'b1;
    end
    ret();
    for (int j = 0; j < 4; j++)
    begin
      pulse(1'b1);
      wait_ack(1);
      wr(8'h00, m_ctrl | 8'h01);
      m_ctrl[0] = 1'b1;
    end
    @(negedge clk);
    chk({11'h0, stack_full}, 12'h001);
    pulse(1'b1);
    repeat (12)
    begin
      @(negedge clk);
      chk({11'h0, irq_ack}, 12'h000);
    end
    rd(8'h00, m_ctrl | 8'h20);
    ret();
    wait_ack(1);
    @(posedge clk);
    power_down <= 1'b1;
    @(negedge clk);
    chk({11'h0, wake}, 12'h000);
    pulse(1'b0);
    @(negedge clk);
    chk({11'h0, wake}, 12'h001);
    rd(8'h00, m_ctrl | 8'h40);
    rd(tsviu_pkg::STATUS_ADDR, 8'h03);
    rd(tsviu_pkg::STACK_ADDR, 8'(tsviu_pkg::STACK_DEPTH));
    // Frozen clock enable must drop an overflow
    @(posedge clk);
    clk_en <= 1'b0;
    pulse(1'b1);
    clk_en <= 1'b1;
    rd(8'h00, m_ctrl | 8'h40);
    // Mid-run reset clears enables, flags and the stack
    @(posedge clk);
    rst_n <= 1'b0;
    @(posedge clk);
    rst_n <= 1'b1;
    rd(tsviu_pkg::STACK_ADDR, 8'h00);
    rd(8'h00, 8'h00);
    final_report();
  end
endmodule
